// ==== hw/adcfl_core.sv ====
`timescale 1ns/1ps

module adcfl_core #(
	parameter int LATENCY = adcfl_pkg::PIPE_LAT,
	parameter int FRAC_W  = adcfl_pkg::FRAC_W
) (
	input  wire logic                          sys_clk_i,               // Sample clock
	input  wire logic                          resetn_i,                // Async reset, low
	input  wire logic [adcfl_pkg::WORD_W+FRAC_W-1:0] raw_code_i,        // Fine quantiser code
	input  wire logic                          sample_valid_i,          // Fine code present
	output logic                               sample_ready_o,          // Pipeline can take
	input  wire logic                          output_format_select_i,  // Format pin
	input  wire logic                          output_format_float_i,   // Format pin open
	input  wire logic                          spur_reduction_select_i, // Spur pin
	output logic [adcfl_pkg::WORD_W-1:0]       word_o,                  // Output word
	output logic                               valid_o,                 // Word present
	input  wire logic                          ready_i,                 // Receiver takes
	output logic                               rate_ok_o                // Sample gap in limit
);

	localparam int W  = adcfl_pkg::WORD_W;
	localparam int FW = W + FRAC_W;
	localparam logic [FRAC_W-1:0] DITHER_MID = FRAC_W'(1) << (FRAC_W - 1);
	localparam logic [FW-1:0]     ZERO_FINE  = FW'(1) << (FW - 1);
	localparam logic [adcfl_pkg::GAP_W-1:0] MAX_GAP =
		adcfl_pkg::GAP_W'(adcfl_pkg::MAX_GAP_CYC);

	if (LATENCY < 2 || FRAC_W < 1 || FRAC_W > adcfl_pkg::LFSR_W)
	begin : g_bad_param
		$error("adcfl_core: LATENCY or FRAC_W out of range");
	end

	function automatic logic [W-1:0] fmt_code(input logic [W-1:0] c, input logic ob);
		fmt_code = ob ? c : {~c[W-1], c[W-2:0]};
	endfunction

	logic [adcfl_pkg::SYNC_N-1:0] pin_raw;
	logic [adcfl_pkg::SYNC_N-1:0] sync1;
	logic [adcfl_pkg::SYNC_N-1:0] sync2;
	adcfl_pkg::adcfl_fmt_e        fmt_q;
	logic                         spur_q;
	logic [adcfl_pkg::LFSR_W-1:0] lfsr;
	logic [FRAC_W-1:0]            dither;
	logic [FW:0]                  sum;
	logic [W-1:0]                 q_now;
	adcfl_pkg::adcfl_stage_s      stage [LATENCY];
	logic [W-1:0]                 last_code;
	logic [W-1:0]                 last_fmt;
	logic                         adv;
	logic                         take;
	logic                         ld;
	logic                         mfree;
	logic                         skid_vld;
	logic [W-1:0]                 skid;
	logic [adcfl_pkg::GAP_W-1:0]  gap;

	assign pin_raw[adcfl_pkg::SYNC_FMT]  = output_format_select_i;
	assign pin_raw[adcfl_pkg::SYNC_FLT]  = output_format_float_i;
	assign pin_raw[adcfl_pkg::SYNC_SPUR] = spur_reduction_select_i;

	// Pins are static straps but still cross in asynchronously
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= pin_raw;
			sync2 <= sync1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			fmt_q  <= adcfl_pkg::ADCFL_FMT_TC;
			spur_q <= 1'b0;
		end
		else
		begin
			// Open pin wins over whatever level it happens to show
			if (sync2[adcfl_pkg::SYNC_FLT])
				fmt_q <= adcfl_pkg::ADCFL_FMT_TC;
			else if (sync2[adcfl_pkg::SYNC_FMT])
				fmt_q <= adcfl_pkg::ADCFL_FMT_OB;
			else
				fmt_q <= adcfl_pkg::ADCFL_FMT_TC;
			spur_q <= sync2[adcfl_pkg::SYNC_SPUR];
		end
	end

	// Threshold sequence only runs while spur reduction is on
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			lfsr <= adcfl_pkg::LFSR_SEED;
		else if (spur_q)
			lfsr <= {lfsr[adcfl_pkg::LFSR_W-2:0], ^(lfsr & adcfl_pkg::LFSR_TAPS)};
	end

	// Mid offset rounds to nearest; random offset moves each threshold
	assign dither = spur_q ? lfsr[FRAC_W-1:0] : DITHER_MID;

	assign sum   = {1'b0, raw_code_i} + {{(W + 1){1'b0}}, dither};
	assign q_now = sum[FW] ? adcfl_pkg::CODE_POS_FS_OB : sum[FW-1:FRAC_W];

	// Whole pipeline stalls together so latency stays fixed in flow
	assign adv            = ~skid_vld | ~stage[LATENCY-1].vld;
	assign take           = sample_valid_i & adv;
	assign sample_ready_o = adv;

	// Head stage split out so no stage ever indexes below zero
	for (genvar k = 0; k < LATENCY; k++)
	begin : g_stage
		if (k == 0)
		begin : g_head
			always_ff @(posedge sys_clk_i or negedge resetn_i)
			begin
				if (!resetn_i)
					stage[k] <= '0;
				else if (adv)
					stage[k] <= '{vld: sample_valid_i, code: q_now};
			end
		end
		else
		begin : g_tail
			always_ff @(posedge sys_clk_i or negedge resetn_i)
			begin
				if (!resetn_i)
					stage[k] <= '0;
				else if (adv)
					stage[k] <= stage[k-1];
			end
		end
	end

	// Coding is applied as the word leaves, so a format change shows first
	// on words already in flight; the receiver must drop those.
	assign last_code = stage[LATENCY-1].code;
	assign last_fmt  = fmt_code(last_code, fmt_q == adcfl_pkg::ADCFL_FMT_OB);
	assign mfree     = ~valid_o | ready_i;
	assign ld        = stage[LATENCY-1].vld & ~skid_vld;

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			valid_o <= 1'b0;
			word_o  <= '0;
		end
		else if (mfree)
		begin
			valid_o <= skid_vld | ld;
			if (skid_vld)
				word_o <= skid;
			else if (ld)
				word_o <= last_fmt;
		end
	end

	// Second entry catches the word that was in flight when ready fell
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			skid_vld <= 1'b0;
			skid     <= '0;
		end
		else if (mfree)
			skid_vld <= 1'b0;
		else if (ld)
		begin
			skid_vld <= 1'b1;
			skid     <= last_fmt;
		end
	end

	// Informative only: the block cannot enforce the clock supplier's rate
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			gap       <= '0;
			rate_ok_o <= 1'b0;
		end
		else if (take)
		begin
			gap       <= '0;
			rate_ok_o <= gap < MAX_GAP;
		end
		else if (gap != '1)
			gap <= gap + 1'b1;
	end

	default clocking cb @(posedge sys_clk_i);
	endclocking

	default disable iff (!resetn_i);

	sequence take_s;
		take;
	endsequence

	sequence flow_s;
		adv[*8] ##1 adv ##1 (adv && mfree);
	endsequence

	// Six idle cycles exceed the five-cycle gap allowed at 50 MHz
	sequence idle_s;
		(!take)[*6];
	endsequence

	spur_sync_a: assert property (
		sync2[adcfl_pkg::SYNC_SPUR] |=> spur_q)
		else $error("spur select high did not enable spur reduction");

	dither_move_a: assert property (
		spur_q |-> dither == lfsr[FRAC_W-1:0] ##1 lfsr != $past(lfsr))
		else $error("thresholds did not move while spur reduction on");

	static_thr_a: assert property (
		!spur_q ##1 !spur_q |-> dither == DITHER_MID && $stable(lfsr))
		else $error("thresholds moved while spur reduction off");

	fmt_float_a: assert property (
		sync2[adcfl_pkg::SYNC_FLT] |=> fmt_q == adcfl_pkg::ADCFL_FMT_TC)
		else $error("open format pin did not select twos complement");

	ob_pass_a: assert property (
		ld && mfree && fmt_q == adcfl_pkg::ADCFL_FMT_OB
		|=> valid_o && word_o == $past(last_code))
		else $error("offset binary word altered");

	tc_flip_a: assert property (
		ld && mfree && fmt_q == adcfl_pkg::ADCFL_FMT_TC
		|=> word_o == {~$past(last_code[W-1]), $past(last_code[W-2:0])})
		else $error("twos complement word wrong");

	ob_zero_a: assert property (
		take && !spur_q && raw_code_i == ZERO_FINE
		|=> stage[0].code == adcfl_pkg::CODE_ZERO_OB)
		else $error("zero input not coded 800");

	ob_full_a: assert property (
		take && raw_code_i == '1 |=> stage[0].code == adcfl_pkg::CODE_POS_FS_OB)
		else $error("full scale not coded fff");

	ob_neg_a: assert property (
		take && !spur_q && raw_code_i == '0
		|=> stage[0].code == adcfl_pkg::CODE_NEG_FS_OB)
		else $error("negative full scale not coded 000");

	tc_zero_a: assert property (
		ld && mfree && fmt_q == adcfl_pkg::ADCFL_FMT_TC
		&& last_code == adcfl_pkg::CODE_ZERO_OB
		|=> word_o == adcfl_pkg::CODE_ZERO_TC)
		else $error("twos complement zero not 000");

	tc_full_a: assert property (
		ld && mfree && fmt_q == adcfl_pkg::ADCFL_FMT_TC
		&& last_code == adcfl_pkg::CODE_POS_FS_OB
		|=> word_o == adcfl_pkg::CODE_POS_FS_TC)
		else $error("twos complement full scale not 7ff");

	tc_neg_a: assert property (
		ld && mfree && fmt_q == adcfl_pkg::ADCFL_FMT_TC
		&& last_code == adcfl_pkg::CODE_NEG_FS_OB
		|=> word_o == adcfl_pkg::CODE_NEG_FS_TC)
		else $error("twos complement negative full scale not 800");

	pipe_lat_a: assert property (
		take_s ##1 flow_s |=> valid_o
		&& word_o == fmt_code($past(q_now, 11), $past(fmt_q) == adcfl_pkg::ADCFL_FMT_OB))
		else $error("word did not leave ten cycles after its sample");

	out_hold_a: assert property (
		valid_o && !ready_i |=> valid_o && $stable(word_o))
		else $error("output word changed while stalled");

	spur_off_a: assert property (
		!sync2[adcfl_pkg::SYNC_SPUR] |=> !spur_q)
		else $error("spur select low did not disable spur reduction");

	fmt_ob_a: assert property (
		sync2[adcfl_pkg::SYNC_FMT] && !sync2[adcfl_pkg::SYNC_FLT] |=> fmt_q == adcfl_pkg::ADCFL_FMT_OB)
		else $error("format select high did not select offset binary");

	rate_slow_a: assert property (
		idle_s ##1 take |=> !rate_ok_o)
		else $error("rate flag high after a long sample gap");

	rate_fast_a: assert property (
		take ##1 take |=> rate_ok_o)
		else $error("rate flag low after back to back samples");

endmodule

// ==== hw/adcfl_pkg.sv ====
package adcfl_pkg;

	// Converted word and conversion pipeline
	localparam int WORD_W   = 12;
	localparam int PIPE_LAT = 10;
	localparam int FRAC_W   = 2;

	// Pin synchroniser lanes
	localparam int SYNC_N    = 3;
	localparam int SYNC_FMT  = 0;
	localparam int SYNC_FLT  = 1;
	localparam int SYNC_SPUR = 2;

	// Sample-rate floor
	localparam int CLK_PERIOD_NS  = 20;
	localparam int MIN_RATE_MSPS  = 10;
	localparam int MIN_PERIOD_NS  = 1000 / MIN_RATE_MSPS;
	localparam int MAX_GAP_CYC    = MIN_PERIOD_NS / CLK_PERIOD_NS;
	localparam int GAP_W          = 8;

	// Threshold sequence generator
	localparam int               LFSR_W    = 16;
	localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;
	localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;

	// Characteristic output codes
	localparam logic [WORD_W-1:0] CODE_POS_FS_OB = 12'hfff;
	localparam logic [WORD_W-1:0] CODE_ZERO_OB   = 12'h800;
	localparam logic [WORD_W-1:0] CODE_NEG_FS_OB = 12'h000;
	localparam logic [WORD_W-1:0] CODE_POS_FS_TC = 12'h7ff;
	localparam logic [WORD_W-1:0] CODE_ZERO_TC   = 12'h000;
	localparam logic [WORD_W-1:0] CODE_NEG_FS_TC = 12'h800;

	typedef enum logic
	{
		ADCFL_FMT_TC = 1'b0,
		ADCFL_FMT_OB = 1'b1
	} adcfl_fmt_e;

	typedef struct packed
	{
		logic              vld;
		logic [WORD_W-1:0] code;
	} adcfl_stage_s;

endpackage

// ==== tb/adcfl_capture.sv ====
`timescale 1ns/1ps
module adcfl_capture (
	input  wire logic                         clk_i,    // Sample clock
	input  wire logic                         resetn_i, // Reset, low
	input  wire logic [adcfl_pkg::WORD_W-1:0] word_i,   // Word in
	input  wire logic                         valid_i,  // Word present
	input  wire logic                         hold_i,   // Stall on request
	output logic                              ready_o   // Takes word
);
	logic [adcfl_pkg::WORD_W-1:0] got[$];
	// Ready moves just after the edge, never on it
	always @(posedge clk_i)
		ready_o <= #1 !hold_i;
	always @(posedge clk_i)
		if (resetn_i && valid_i && ready_o)
			got.push_back(word_i);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
	localparam int RW = adcfl_pkg::WORD_W + adcfl_pkg::FRAC_W;
	localparam int WW = adcfl_pkg::WORD_W;
	logic          sys_clk_i = 1'b0;
	logic          resetn_i  = 1'b0;
	logic [RW-1:0] raw_code_i = '0;
	logic          sample_valid_i = 1'b0;
	logic          fmt = 1'b0;
	logic          flt = 1'b0;
	logic          spur = 1'b0;
	logic          hold = 1'b0;
	logic          sample_ready_o, valid_o, ready_i, rate_ok_o;
	logic [WW-1:0] word_o;
	logic [RW-1:0] rq[$];
	int            err_total, checks_done, cyc;
	always #10 sys_clk_i = ~sys_clk_i;
	adcfl_core u_adcfl_core (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .raw_code_i(raw_code_i),
		.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o), .output_format_select_i(fmt),
		.output_format_float_i(flt), .spur_reduction_select_i(spur), .word_o(word_o), .valid_o(valid_o),
		.ready_i(ready_i), .rate_ok_o(rate_ok_o));
	adcfl_capture u_adcfl_capture (.clk_i(sys_clk_i), .resetn_i(resetn_i), .word_i(word_o),
		.valid_i(valid_o), .hold_i(hold), .ready_o(ready_i));
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			print_verdict();
		end
	end
	task chk(input logic [WW-1:0] exp, input logic [WW-1:0] got);
		checks_done++;
		if (exp !== got)
		begin
			err_total++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	// Sends rq back to back; each sample held until taken
	task burst;
		logic r;
		@(posedge sys_clk_i);
		foreach (rq[i])
		begin
			#1 raw_code_i = rq[i];
			sample_valid_i = 1'b1;
			do
			begin
				@(negedge sys_clk_i) r = sample_ready_o;
				@(posedge sys_clk_i);
			end while (!r);
		end
		#1 sample_valid_i = 1'b0;
		rq.delete();
	endtask
	task drain(input int n);
		for (int k = 0; k < 400 && u_adcfl_capture.got.size() < n; k++)
			@(posedge sys_clk_i);
		chk(WW'(n), WW'(u_adcfl_capture.got.size()));
	endtask
	// Settings are static; wait out sync and pipeline before use
	task pins(input logic f, input logic l, input logic s);
		@(posedge sys_clk_i);
		#1 fmt = f;
		flt = l;
		spur = s;
		repeat (20) @(posedge sys_clk_i);
	endtask
	task t_codes;
		logic [WW-1:0] ob[4];
		ob = '{12'h000, 12'h800, 12'hfff, 12'h7ff};
		for (int m = 0; m < 3; m++)
		begin
			pins(m != 1, m == 2, 1'b0);
			rq = '{14'h0000, 14'h2000, 14'h3fff, 14'h1ffc};
			burst();
			drain(4);
			foreach (ob[i])
				chk(m == 0 ? ob[i] : ob[i] ^ 12'h800, u_adcfl_capture.got.pop_front());
		end
	endtask
	task t_latency;
		int k;
		pins(1'b1, 1'b0, 1'b0);
		rq = '{14'h2000};
		burst();
		for (k = 1; k < 30; k++)
		begin
			@(posedge sys_clk_i) #2;
			if (valid_o === 1'b1)
				break;
		end
		chk(12'h00a, WW'(k));
		drain(1);
		chk(12'h800, u_adcfl_capture.got.pop_front());
		// Lone sample after a long idle spell must show a slow rate
		chk(12'h000, {11'h000, rate_ok_o});
	endtask
	// Receiver stalls long enough to fill the two-entry buffer
	task t_stall;
		@(posedge sys_clk_i) #1 hold = 1'b1;
		for (int i = 0; i < 16; i++)
			rq.push_back(RW'(4 * i));
		fork
			burst();
			begin
				repeat (30) @(posedge sys_clk_i);
				chk(12'h000, {11'h000, sample_ready_o});
				#1 hold = 1'b0;
			end
		join
		drain(16);
		for (int i = 0; i < 16; i++)
			chk(WW'(i), u_adcfl_capture.got.pop_front());
		chk(12'h001, {11'h000, rate_ok_o});
	endtask
	task t_spur;
		int hi;
		for (int s = 1; s >= 0; s--)
		begin
			pins(1'b1, 1'b0, s[0]);
			for (int i = 0; i < 32; i++)
				rq.push_back(14'h2002);
			burst();
			drain(32);
			hi = 0;
			while (u_adcfl_capture.got.size() > 0)
				if (u_adcfl_capture.got.pop_front() === 12'h801)
					hi++;
			if (s == 1)
				chk(12'h001, {11'h000, hi > 0 && hi < 32});
			else
				chk(12'h020, WW'(hi));
		end
	endtask
	initial
	begin
		repeat (20) @(posedge sys_clk_i);
		#1 resetn_i = 1'b1;
		@(posedge sys_clk_i) #1;
		chk(12'h000, word_o);
		chk(12'h000, {11'h000, valid_o});
		chk(12'h001, {11'h000, sample_ready_o});
		t_codes();
		t_latency();
		t_stall();
		t_spur();
		print_verdict();
	end
endmodule
